// file: pkg/aux_adc_pkg.sv
package aux_adc_pkg;

  // ****************************************************************
  // Register map and reset values
  // ****************************************************************
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] STEP11_OFS = 8'h98;
  localparam logic [ADR_W-1:0] STEP12_OFS = 8'h9C;
  localparam logic [ADR_W-1:0] STATUS_OFS = 8'hA0;
  localparam logic [15:0] STEP11_RST = 16'h000B;
  localparam logic [15:0] STEP12_RST = 16'h000C;
  localparam logic [15:0] CFG_WMASK = 16'hE01F;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int EN_BIT = 15;
  localparam int GAIN_HI = 14;
  localparam int GAIN_LO = 13;
  localparam int NEG_BIT = 4;
  localparam int POS_HI = 3;
  localparam int POS_LO = 0;

  // ****************************************************************
  // Positive selector codes, step numbers and gain cap code
  // ****************************************************************
  localparam logic [3:0] POS_EXT_LAST = 4'h7;
  localparam logic [3:0] POS_TEMP_A = 4'h8;
  localparam logic [3:0] POS_SHORT_GND = 4'h9;
  localparam logic [3:0] POS_TEST_DAC_B = 4'hA;
  localparam logic [3:0] POS_UNUSED = 4'hB;
  localparam logic [3:0] POS_IO_DIV4 = 4'hC;
  localparam logic [3:0] POS_CORE_DIV2 = 4'hD;
  localparam logic [3:0] POS_ANALOG_POWER_INPUT_DIV103 = 4'hE;
  localparam logic [3:0] POS_DIGITAL_POWER_INPUT_DIV103 = 4'hF;
  localparam logic [3:0] STEP11_NUM = 4'hB;
  localparam logic [3:0] STEP12_NUM = 4'hC;
  localparam logic [1:0] GAIN_X4 = 2'h2;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic valid;
    logic [3:0] step;
    logic enable;
    logic [1:0] gain_log2;
    logic [3:0] pos_code;
    logic ext_pos;
    logic [2:0] ext_index;
    logic neg_auto;
    logic neg_input7;
  } mux_sel_t;

  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_t;

endpackage

// file: verilog/aux_adc_step_input_select.sv
// Contract
// - Codes 0-7 route external inputs 0-7.
// - Code 8 selects temperature sensor A, auto negative.
// - Code 9 shorts input to ground, auto negative.
// - Code 10 selects test DAC B, auto negative.
// - Codes 12-15 select supply monitors, auto negative.
// - Auto negative codes ignore negative selector bit.
// - Negative bit 4, reset 0: ground or input 7.
// - Positive selector bits 3:0, resets to 1011b in step 11, 1100b in step 12.
// - Step-12 register at 9Ch, resets 000Ch.
// - Enable bit 15, gain 14:13, 12:5 read zero.
module aux_adc_step_input_select (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire aux_adc_pkg::wb_req_t wb_i,
  output aux_adc_pkg::wb_rsp_t wb_o,
  input wire logic seq_step_valid_i,
  input wire logic [3:0] seq_step_i,
  output aux_adc_pkg::mux_sel_t mux_sel_o
);
  import aux_adc_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic mux_sel_t decode_step(
    input logic [15:0] cfg,
    input logic [3:0] step
  );
    mux_sel_t res;
    logic [3:0] pos;
    res = '0;
    pos = cfg[POS_HI:POS_LO];
    res.step = step;
    res.enable = cfg[EN_BIT];
    res.pos_code = pos;
    // Gain codes 10b and 11b both give four.
    res.gain_log2 = (cfg[GAIN_HI:GAIN_LO] > GAIN_X4) ? GAIN_X4 : cfg[GAIN_HI:GAIN_LO];
    res.valid = (pos != POS_UNUSED);
    res.ext_pos = (pos <= POS_EXT_LAST);
    res.ext_index = pos[2:0];
    // Every internal source picks its own negative input.
    res.neg_auto = (pos == POS_TEMP_A) || (pos == POS_SHORT_GND) ||
                   (pos == POS_TEST_DAC_B) || (pos >= POS_IO_DIV4);
    // The negative bit only matters for external positive inputs.
    res.neg_input7 = res.ext_pos && cfg[NEG_BIT];
    return res;
  endfunction

  function automatic logic [15:0] write_cfg(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] sel
  );
    logic [15:0] lanes;
    lanes = {{8{sel[1]}}, {8{sel[0]}}};
    // Reserved bits never take a write, so they always read zero.
    return ((old & ~lanes) | (data[15:0] & lanes)) & CFG_WMASK;
  endfunction

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [15:0] step11_config;
  logic [15:0] step12_config;
  logic [15:0] next_step11_config;
  logic [15:0] next_step12_config;
  bus_state_t bus_state;
  bus_state_t next_bus_state;
  wb_rsp_t next_wb;
  mux_sel_t next_mux_sel;
  logic req;
  logic wr_commit;

  assign req = wb_i.cyc && wb_i.stb;
  // A write lands on the edge where the master sees the acknowledge.
  assign wr_commit = req && wb_i.we && (bus_state == BUS_ACK);

  always_comb begin
    next_step11_config = step11_config;
    next_step12_config = step12_config;
    if (wr_commit) begin
      if (wb_i.adr == STEP11_OFS) begin
        next_step11_config = write_cfg(step11_config, wb_i.dat, wb_i.sel);
      end else if (wb_i.adr == STEP12_OFS) begin
        next_step12_config = write_cfg(step12_config, wb_i.dat, wb_i.sel);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step11_config <= STEP11_RST;
      step12_config <= STEP12_RST;
    end else begin
      step11_config <= next_step11_config;
      step12_config <= next_step12_config;
    end
  end

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  always_comb begin
    next_bus_state = bus_state;
    next_wb = '0;
    case (bus_state)
      BUS_IDLE: begin
        if (req) begin
          next_bus_state = BUS_ACK;
          next_wb.ack = 1'b1;
          // Unmapped addresses still acknowledge and read zero.
          if (wb_i.adr == STEP11_OFS) begin
            next_wb.dat = {16'h0000, step11_config};
          end else if (wb_i.adr == STEP12_OFS) begin
            next_wb.dat = {16'h0000, step12_config};
          end else if (wb_i.adr == STATUS_OFS) begin
            next_wb.dat = 32'(mux_sel_o);
          end
        end
      end
      BUS_ACK: begin
        next_bus_state = BUS_IDLE;
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= BUS_IDLE;
      wb_o <= '0;
    end else begin
      bus_state <= next_bus_state;
      wb_o <= next_wb;
    end
  end

  // ****************************************************************
  // Step selection
  // ****************************************************************
  always_comb begin
    next_mux_sel = '0;
    if (seq_step_valid_i) begin
      if (seq_step_i == STEP11_NUM) begin
        next_mux_sel = decode_step(step11_config, STEP11_NUM);
      end else if (seq_step_i == STEP12_NUM) begin
        next_mux_sel = decode_step(step12_config, STEP12_NUM);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mux_sel_o <= '0;
    end else begin
      mux_sel_o <= next_mux_sel;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic at11;
  logic at12;
  // Step hits as the sequencer presents them; the selection answers one edge later.
  assign at11 = seq_step_valid_i && (seq_step_i == STEP11_NUM);
  assign at12 = seq_step_valid_i && (seq_step_i == STEP12_NUM);

  AST_EXT_ROUTE: assert property (
    at11 && (step11_config[POS_HI:POS_LO] <= POS_EXT_LAST)
    |=> mux_sel_o.ext_pos && mux_sel_o.valid
        && (mux_sel_o.ext_index == $past(step11_config[2:0]))
  ) else $error("External input not routed.");

  AST_TEMP_AUTO: assert property (
    at11 && (step11_config[POS_HI:POS_LO] == POS_TEMP_A)
    |=> mux_sel_o.neg_auto && !mux_sel_o.ext_pos && (mux_sel_o.pos_code == POS_TEMP_A)
  ) else $error("Temperature sensor selection wrong.");

  AST_SHORT_GND: assert property (
    at11 && (step11_config[POS_HI:POS_LO] == POS_SHORT_GND)
    |=> mux_sel_o.neg_auto && !mux_sel_o.ext_pos && (mux_sel_o.pos_code == POS_SHORT_GND)
  ) else $error("Ground short selection wrong.");

  AST_TEST_DAC: assert property (
    at11 && (step11_config[POS_HI:POS_LO] == POS_TEST_DAC_B)
    |=> mux_sel_o.neg_auto && mux_sel_o.valid && !mux_sel_o.ext_pos
  ) else $error("Test DAC selection wrong.");

  AST_SUPPLY: assert property (
    at11 && (step11_config[POS_HI:POS_LO] >= POS_IO_DIV4)
    |=> mux_sel_o.neg_auto && (mux_sel_o.pos_code == $past(step11_config[POS_HI:POS_LO]))
  ) else $error("Supply monitor selection wrong.");

  AST_NEG_IGNORED: assert property (
    mux_sel_o.neg_auto |-> !mux_sel_o.neg_input7
  ) else $error("Negative bit used with automatic negative.");

  AST_NEG_SEL: assert property (
    at11 && (step11_config[POS_HI:POS_LO] <= POS_EXT_LAST)
    |=> mux_sel_o.neg_input7 == $past(step11_config[NEG_BIT])
  ) else $error("Negative selector not applied.");

  AST_STEP11_RESET: assert property (
    $past(rst_i) |-> (step11_config == STEP11_RST) && !wb_o.ack
  ) else $error("Step 11 reset value wrong.");

  AST_STEP12_READ: assert property (
    (bus_state == BUS_IDLE) && req && !wb_i.we && (wb_i.adr == STEP12_OFS)
    |=> wb_o.ack && (wb_o.dat == {16'h0000, $past(step12_config)})
  ) else $error("Step 12 readback wrong.");

  AST_RSVD_ZERO: assert property (
    ((step11_config & ~CFG_WMASK) == 16'h0000) && ((step12_config & ~CFG_WMASK) == 16'h0000)
  ) else $error("Reserved bits not zero.");

  AST_ACK_ONE: assert property (
    (bus_state == BUS_IDLE) && req |=> wb_o.ack ##1 !wb_o.ack
  ) else $error("Acknowledge not a single cycle.");

  AST_STEP_APPLY: assert property (
    seq_step_valid_i && (seq_step_i == STEP12_NUM)
    |=> (mux_sel_o.step == STEP12_NUM) && (mux_sel_o.pos_code == $past(step12_config[POS_HI:POS_LO]))
  ) else $error("Step 12 code not applied.");

  AST_STEP11_FIELDS: assert property (
    at11
    |=> (mux_sel_o.step == STEP11_NUM) && (mux_sel_o.enable == $past(step11_config[EN_BIT]))
        && (mux_sel_o.pos_code == $past(step11_config[POS_HI:POS_LO]))
  ) else $error("Step 11 fields not carried.");

  // Both upper gain codes mean four, so the saturated code is checked apart.
  AST_GAIN_SAT: assert property (
    at11 && (&step11_config[GAIN_HI:GAIN_LO])
    |=> mux_sel_o.gain_log2 == GAIN_X4
  ) else $error("Top gain code not mapped to four.");

  AST_GAIN_PASS: assert property (
    at11 && !(&step11_config[GAIN_HI:GAIN_LO])
    |=> mux_sel_o.gain_log2 == $past(step11_config[GAIN_HI:GAIN_LO])
  ) else $error("Gain code not passed through.");

  // The reset code names no input, so it must never look like a valid pick.
  AST_UNUSED_CODE: assert property (
    at11 && (step11_config[POS_HI:POS_LO] == POS_UNUSED)
    |=> !mux_sel_o.valid && !mux_sel_o.neg_auto && !mux_sel_o.ext_pos
  ) else $error("Unused code gives a selection.");

  AST_EXT_NOT_AUTO: assert property (
    at11 && (step11_config[POS_HI:POS_LO] <= POS_EXT_LAST)
    |=> !mux_sel_o.neg_auto
  ) else $error("External input flagged as automatic negative.");

  AST_NEG_GROUND: assert property (
    at11 && (step11_config[POS_HI:POS_LO] <= POS_EXT_LAST) && !step11_config[NEG_BIT]
    |=> mux_sel_o.valid && !mux_sel_o.neg_input7
  ) else $error("Ground not chosen as negative input.");

  // A stale selection while the sequencer is elsewhere would steer the wrong input.
  AST_IDLE_ZERO: assert property (
    !seq_step_valid_i |=> mux_sel_o == '0
  ) else $error("Selection present without a step.");

  AST_OTHER_STEP_ZERO: assert property (
    seq_step_valid_i && !at11 && !at12
    |=> mux_sel_o == '0
  ) else $error("Selection present for a foreign step.");

  AST_STEP12_FIELDS: assert property (
    at12
    |=> (mux_sel_o.step == STEP12_NUM) && (mux_sel_o.enable == $past(step12_config[EN_BIT]))
  ) else $error("Step 12 fields not carried.");

  AST_STEP12_EXT: assert property (
    at12 && (step12_config[POS_HI:POS_LO] <= POS_EXT_LAST)
    |=> mux_sel_o.ext_pos && !mux_sel_o.neg_auto && (mux_sel_o.ext_index == $past(step12_config[2:0]))
        && (mux_sel_o.neg_input7 == $past(step12_config[NEG_BIT]))
  ) else $error("Step 12 external input not routed.");

  AST_STEP12_AUTO: assert property (
    at12 && (step12_config[POS_HI:POS_LO] > POS_EXT_LAST) && (step12_config[POS_HI:POS_LO] != POS_UNUSED)
    |=> mux_sel_o.neg_auto && !mux_sel_o.neg_input7 && !mux_sel_o.ext_pos
  ) else $error("Step 12 internal source without automatic negative.");

  AST_STEP12_RESET: assert property (
    $past(rst_i) |-> (step12_config == STEP12_RST) && (mux_sel_o == '0)
  ) else $error("Step 12 reset value wrong.");

  // Both byte lanes on, so the whole writable part of the word must land.
  AST_STEP11_WRITE: assert property (
    wr_commit && (wb_i.adr == STEP11_OFS) && (&wb_i.sel[1:0])
    |=> step11_config == ($past(wb_i.dat[15:0]) & CFG_WMASK)
  ) else $error("Step 11 write lost.");

  AST_STEP12_WRITE: assert property (
    wr_commit && (wb_i.adr == STEP12_OFS) && (&wb_i.sel[1:0])
    |=> step12_config == ($past(wb_i.dat[15:0]) & CFG_WMASK)
  ) else $error("Step 12 write lost.");

  // Nothing but an acknowledged write may move a configuration word.
  AST_HOLD_NO_WRITE: assert property (
    !wr_commit |=> $stable(step11_config) && $stable(step12_config)
  ) else $error("Configuration changed without a write.");

  AST_UNMAPPED_ZERO: assert property (
    (bus_state == BUS_IDLE) && req && (wb_i.adr != STEP11_OFS) && (wb_i.adr != STEP12_OFS)
    && (wb_i.adr != STATUS_OFS)
    |=> wb_o.ack && (wb_o.dat == '0)
  ) else $error("Unmapped address returned data.");

  AST_STEP11_READ: assert property (
    (bus_state == BUS_IDLE) && req && !wb_i.we && (wb_i.adr == STEP11_OFS)
    |=> wb_o.ack && (wb_o.dat == {16'h0000, $past(step11_config)})
  ) else $error("Step 11 readback wrong.");

  AST_STATUS_READ: assert property (
    (bus_state == BUS_IDLE) && req && !wb_i.we && (wb_i.adr == STATUS_OFS)
    |=> wb_o.ack && (wb_o.dat == 32'($past(mux_sel_o)))
  ) else $error("Status readback wrong.");

  // An acknowledge without a fresh request would let the master run ahead of the slave.
  AST_NO_SPURIOUS_ACK: assert property (
    ((bus_state == BUS_ACK) || !req) |=> !wb_o.ack
  ) else $error("Acknowledge without a request.");

  AST_DAT_QUIET: assert property (
    !wb_o.ack |-> (wb_o.dat == '0)
  ) else $error("Read data outside an acknowledge.");

  COV_EXT_NEG7: cover property (at11 ##1 mux_sel_o.neg_input7);
  COV_AUTO: cover property (at11 ##1 mux_sel_o.neg_auto);
  COV_WRITE: cover property (wr_commit && (wb_i.adr == STEP11_OFS));
  COV_STEP12: cover property (seq_step_valid_i && (seq_step_i == STEP12_NUM));
  COV_STEP12_WRITE: cover property (wr_commit && (wb_i.adr == STEP12_OFS));

endmodule

// file: test/aux_adc_step_input_select_tb.sv
module aux_adc_step_input_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import aux_adc_pkg::*;

  // ****************************************************************
  // Signals and scoreboard
  // ****************************************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t wb_i = '0;
  wb_rsp_t wb_o;
  logic seq_step_valid_i = 1'b0;
  logic [3:0] seq_step_i = 4'h0;
  mux_sel_t mux_sel_o;
  logic [31:0] exp_q[$];
  int miscompares = 0;
  int compares = 0;
  logic [15:0] cfg;
  logic [31:0] exp_val;

  aux_adc_step_input_select u_aux_adc_step_input_select (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_i(wb_i),
    .wb_o(wb_o),
    .seq_step_valid_i(seq_step_valid_i),
    .seq_step_i(seq_step_i),
    .mux_sel_o(mux_sel_o)
  );

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
    compares++;
    if (seen !== expected) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, expected, seen);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ****************************************************************
  // Bus master: holds the request until ack is sampled high.
  // ****************************************************************
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    do @(posedge clk_i); while (wb_o.ack !== 1'b1);
    wb_i <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] expected);
    exp_q.push_back(expected);
    bus(1'b0, adr, 32'h0000_0000, 4'hF);
  endtask

  function automatic logic [31:0] mux_exp(input logic [15:0] c, input logic [3:0] s);
    mux_sel_t m;
    m = '0;
    m.valid = (c[3:0] != POS_UNUSED);
    m.step = s;
    m.enable = c[EN_BIT];
    m.gain_log2 = (c[14:13] == 2'h3) ? 2'h2 : c[14:13];
    m.pos_code = c[3:0];
    m.ext_pos = (c[3:0] <= 4'h7);
    m.ext_index = c[2:0];
    m.neg_auto = !m.ext_pos && m.valid;
    m.neg_input7 = m.ext_pos & c[NEG_BIT];
    return 32'(m);
  endfunction

  // ****************************************************************
  // Monitor: every read answer is matched to the oldest note.
  // ****************************************************************
  always @(posedge clk_i) begin
    if (wb_o.ack === 1'b1 && wb_i.we === 1'b0) begin
      if (exp_q.size() == 0) check("unexpected ack", 32'h0000_0001, 32'h0000_0000);
      else begin
        exp_val = exp_q.pop_front();
        check("read data", wb_o.dat, exp_val);
        if (wb_i.adr == STATUS_OFS) check("mux select", 32'(mux_sel_o), exp_val);
      end
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    void'($urandom(32'h4FCC));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(STEP11_OFS, 32'h0000_000B);
    rd_chk(STEP12_OFS, 32'h0000_000C);
    rd_chk(8'hA4, 32'h0000_0000);
    seq_step_valid_i <= 1'b1;
    seq_step_i <= STEP12_NUM;
    rd_chk(STATUS_OFS, mux_exp(STEP12_RST, STEP12_NUM));
    seq_step_valid_i <= 1'b0;
    bus(1'b1, STEP12_OFS, 32'hFFFF_FFFF, 4'hF);
    rd_chk(STEP12_OFS, 32'h0000_E01F);
    bus(1'b1, STEP12_OFS, 32'h0000_0000, 4'h1);
    rd_chk(STEP12_OFS, 32'h0000_E000);
    for (int p = 0; p < 16; p++) begin
      cfg = 16'($urandom());
      cfg[3:0] = 4'(p);
      cfg[NEG_BIT] = cfg[NEG_BIT] ^ 1'(p >> 1);
      bus(1'b1, STEP11_OFS, {16'($urandom()), cfg}, 4'h3);
      rd_chk(STEP11_OFS, {16'h0000, cfg & 16'hE01F});
      seq_step_valid_i <= 1'b1;
      seq_step_i <= STEP11_NUM;
      // A status read reflects the decoded selection while the step is held.
      rd_chk(STATUS_OFS, mux_exp(cfg, STEP11_NUM));
      seq_step_valid_i <= 1'b0;
    end
    seq_step_valid_i <= 1'b1;
    seq_step_i <= STEP12_NUM;
    rd_chk(STATUS_OFS, mux_exp(16'hE000, STEP12_NUM));
    seq_step_i <= 4'h5;
    rd_chk(STATUS_OFS, 32'h0000_0000);
    seq_step_valid_i <= 1'b0;
    seq_step_i <= STEP11_NUM;
    rd_chk(STATUS_OFS, 32'h0000_0000);
    // A reset in mid-run must bring back both reset words.
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(STEP11_OFS, {16'h0000, STEP11_RST});
    rd_chk(STEP12_OFS, {16'h0000, STEP12_RST});
    repeat (2) @(posedge clk_i);
    stop_test();
  end

  initial begin
    #(100 * 4000);
    miscompares++;
    stop_test();
  end
endmodule
